// ### dv/udcms_pins.sv
// Behavioural model of the external count-clock and direction pins.
`timescale 1ns/10ps
`default_nettype none
module udcms_pins (
   input wire logic core_clk_in,
   input wire logic load_in,
   input wire logic [1:0] lvl_in,
   input wire logic step_in,
   input wire logic fwd_in,
   output logic ext_count_clock_pin_out,
   output logic ext_direction_pin_out
);
   logic c_r = 1'b0;
   logic d_r = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // A load sets both levels; a step moves one quadrature phase, forward lets
   // the clock pin lead.
   always_ff @(posedge core_clk_in) begin
      if (load_in) begin
         c_r <= lvl_in[0];
         d_r <= lvl_in[1];
      end else if (step_in) begin
         c_r <= fwd_in ? ~d_r : d_r;
         d_r <= fwd_in ? c_r : ~c_r;
      end
   end
   assign ext_count_clock_pin_out = c_r;
   assign ext_direction_pin_out = d_r;
endmodule
`default_nettype wire

// ### dv/udcms_top_tb.sv
// Self-checking testbench of the count-source selection block.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value %s expected %0h seen %0h", what, e, g); end end
module udcms_top_tb;
   import udcms_pkg::*;
   logic core_clk_in = 0, resetn_in = 0, wr = 0, rd = 0, bit_acc = 0, updown_counter_mode = 0, run = 0;
   logic ld = 0, stp = 0, fwd = 0;
   logic ce = 1'b1;
   logic [31:0] addr = CSMS_ADDR;
   logic [2:0] idx = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [1:0] lvl = 2'h0, csel = 2'h0, dsel = 2'h0;
   logic [15:0] exp_cnt = 16'h0000;
   wire logic pin_c, pin_d, tick, up;
   wire logic [7:0] rdata;
   wire logic [CNT_W-1:0] cnt;
   int n_errors = 0;
   int num_checks = 0;
   udcms_top DUT (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(ce),
      .addr_in(addr), .wr_en_in(wr), .rd_en_in(rd), .bit_access_in(bit_acc),
      .bit_idx_in(idx), .wdata_in(wdata), .updown_counter_mode_in(updown_counter_mode),
      .counter_run_enable_in(run), .clk_edge_sel_in(csel), .dir_edge_sel_in(dsel),
      .ext_count_clock_pin_in(pin_c), .ext_direction_pin_in(pin_d), .rdata_out(rdata),
      .main_counter_out(cnt), .count_tick_out(tick), .count_up_out(up));
   udcms_pins u_pins (.core_clk_in(core_clk_in), .load_in(ld), .lvl_in(lvl), .step_in(stp),
      .fwd_in(fwd), .ext_count_clock_pin_out(pin_c), .ext_direction_pin_out(pin_d));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic b, input logic [2:0] i, input logic [7:0] d);
      @(posedge core_clk_in);
      wr <= 1'b1;
      bit_acc <= b;
      idx <= i;
      wdata <= d;
      addr <= CSMS_ADDR;
      @(posedge core_clk_in);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
      @(posedge core_clk_in);
      rd <= 1'b1;
      bit_acc <= 1'b0;
      addr <= a;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1;
      `CHECK("rdata", e, rdata)
   endtask
   task automatic rd_bit(input logic [2:0] i, input logic e);
      @(posedge core_clk_in);
      rd <= 1'b1;
      bit_acc <= 1'b1;
      idx <= i;
      addr <= CSMS_ADDR;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1;
      `CHECK("rdata bit", {7'h00, e}, rdata)
   endtask
   // The select register is only written while the counter is stopped.
   task automatic setm(input logic u, input logic [2:0] code, input logic [1:0] sel);
      @(posedge core_clk_in);
      run <= 1'b0;
      // Timer mode is entered before the write, so field bit 2 is never cleared in updown mode.
      if (!u) begin
         updown_counter_mode <= 1'b0;
      end
      wr_reg(1'b0, 3'h0, {5'h00, code});
      @(posedge core_clk_in);
      updown_counter_mode <= u;
      csel <= sel;
      dsel <= sel;
      run <= 1'b1;
   endtask
   task automatic settle(input int dlt);
      repeat (3) @(posedge core_clk_in);
      #1;
      exp_cnt = exp_cnt + 16'(dlt);
      `CHECK("counter", exp_cnt, cnt)
      if (dlt != 0) `CHECK("direction", 1'(dlt > 0), up)
   endtask
   task automatic pins(input logic [1:0] l, input int dlt);
      @(posedge core_clk_in);
      ld <= 1'b1;
      lvl <= l;
      @(posedge core_clk_in);
      ld <= 1'b0;
      settle(dlt);
   endtask
   task automatic quad(input logic f, input int dlt);
      @(posedge core_clk_in);
      stp <= 1'b1;
      fwd <= f;
      @(posedge core_clk_in);
      stp <= 1'b0;
      settle(dlt);
   endtask
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge core_clk_in);
         #1;
         n++;
      end while (tick !== 1'b1 && n < 300);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd_chk(CSMS_ADDR, 8'h07);
      rd_chk(CSMS_ADDR + 32'h1, 8'h00);
      wr_reg(1'b1, 3'h1, 8'h00);
      wr_reg(1'b1, 3'h5, 8'h01);
      rd_chk(CSMS_ADDR, 8'h05);
      wr_reg(1'b0, 3'h0, 8'hfa);
      rd_chk(CSMS_ADDR, 8'h02);
      rd_bit(3'h1, 1'b1);
      rd_bit(3'h0, 1'b0);
      rd_bit(3'h6, 1'b0);
   endtask
   // Lower pin levels are {direction, clock}; edge selects set to falling must not matter.
   task automatic t_modes123();
      setm(1'b1, SEL_UDC_MODE1, 2'h0);
      pins(2'b10, 0);
      pins(2'b11, -1);
      pins(2'b00, 0);
      pins(2'b01, 1);
      pins(2'b00, 0);
      setm(1'b1, SEL_UDC_MODE2, 2'h0);
      pins(2'b01, 1);
      pins(2'b00, 0);
      pins(2'b10, -1);
      pins(2'b00, 0);
      setm(1'b1, SEL_UDC_MODE3, 2'h0);
      pins(2'b10, 0);
      pins(2'b11, 1);
      pins(2'b00, 0);
      pins(2'b01, -1);
      pins(2'b00, 0);
   endtask
   task automatic t_mode4();
      setm(1'b1, SEL_UDC_MODE4, EDGE_BOTH);
      repeat (4) quad(1'b1, 1);
      repeat (4) quad(1'b0, -1);
      // Rising edges only: the two falling steps of a forward cycle must not count.
      setm(1'b1, SEL_UDC_MODE4, EDGE_RISE);
      repeat (2) quad(1'b1, 1);
      repeat (2) quad(1'b1, 0);
      // An edge that arrives while the clock enable is low counts once it is high again.
      @(posedge core_clk_in);
      ce <= 1'b0;
      quad(1'b1, 0);
      @(posedge core_clk_in);
      ce <= 1'b1;
      settle(1);
      quad(1'b0, 0);
   endtask
   task automatic t_timer();
      int n;
      setm(1'b0, SEL_PROHIBITED, 2'h0);
      repeat (256) @(posedge core_clk_in);
      pins(2'b01, 0);
      pins(2'b00, 0);
      for (int c = 1; c < 8; c++) begin
         setm(1'b0, 3'(c), 2'h0);
         wait_tick(n);
         wait_tick(n);
         `CHECK("tick gap", 1 << c, n)
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   initial begin
      repeat (10) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      t_regs();
      t_modes123();
      t_mode4();
      t_timer();
      tally_and_finish();
   end
   initial begin
      #500000;
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ### hdl/udcms_edge.sv
// Edge detector for the two external count pins.
`timescale 1ns/10ps
`default_nettype none
module udcms_edge (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [1:0] pin_in,
   udcms_if.producer edges
);
   logic [1:0] prev_r;

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         prev_r <= 2'h0;
      end else if (ce_in) begin
         prev_r <= pin_in;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_pin
      assign edges.lvl[i] = pin_in[i];
      assign edges.rise[i] = pin_in[i] & ~prev_r[i];
      assign edges.fall[i] = ~pin_in[i] & prev_r[i];
   end
endmodule
`default_nettype wire

// ### hdl/udcms_if.sv
// Interface carrying pin levels and edge pulses between edge detector and core.
`timescale 1ns/10ps
`default_nettype none
interface udcms_if;
   logic [1:0] lvl;
   logic [1:0] rise;
   logic [1:0] fall;
   modport producer (output lvl, output rise, output fall);
   modport consumer (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// ### hdl/udcms_pkg.sv
// Package with the constants of the up/down counter count-source selection block.
package udcms_pkg;
   localparam logic [31:0] CSMS_ADDR = 32'h0ffff5ee;
   localparam logic [2:0] CSMS_RESET = 3'h7;
   localparam int CSMS_FIELD_W = 3;
   localparam int PRESC_W = 7;
   localparam int CNT_W = 16;
   localparam int PIN_CLK = 0;
   localparam int PIN_DIR = 1;
   localparam logic [2:0] SEL_PROHIBITED = 3'h0;
   localparam logic [2:0] SEL_UDC_MODE1 = 3'h4;
   localparam logic [2:0] SEL_UDC_MODE2 = 3'h5;
   localparam logic [2:0] SEL_UDC_MODE3 = 3'h6;
   localparam logic [2:0] SEL_UDC_MODE4 = 3'h7;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Source of count events; one-hot codes.
   typedef enum logic [2:0] {
      SRC_NONE = 3'b001,
      SRC_PRESC = 3'b010,
      SRC_PIN = 3'b100
   } udcms_src_t;
endpackage

// ### hdl/udcms_top.sv
// Count-source and count-mode selection with the 16-bit up/down main counter.
`timescale 1ns/10ps
`default_nettype none
module udcms_top #(
   parameter int CNT_WIDTH = udcms_pkg::CNT_W
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [31:0] addr_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic bit_access_in,
   input wire logic [2:0] bit_idx_in,
   input wire logic [7:0] wdata_in,
   input wire logic updown_counter_mode_in,
   input wire logic counter_run_enable_in,
   input wire logic [1:0] clk_edge_sel_in,
   input wire logic [1:0] dir_edge_sel_in,
   input wire logic ext_count_clock_pin_in,
   input wire logic ext_direction_pin_in,
   output logic [7:0] rdata_out,
   output logic [CNT_WIDTH-1:0] main_counter_out,
   output logic count_tick_out,
   output logic count_up_out
);
   import udcms_pkg::*;

   logic [CSMS_FIELD_W-1:0] csms_r;
   logic [PRESC_W-1:0] presc_r;
   logic [CNT_WIDTH-1:0] cnt_r;
   logic [7:0] rdata_r;
   logic tick_r;
   logic up_r;
   logic hit;
   logic [7:0] reg_byte;
   logic [7:0] div_mask;
   logic presc_tick;
   logic ev;
   logic up;
   logic clk_en;
   logic dir_en;
   udcms_src_t src;

   udcms_if edges ();

   udcms_edge u_edge (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .pin_in({ext_direction_pin_in, ext_count_clock_pin_in}),
      .edges(edges)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register port.

   assign hit = (addr_in == CSMS_ADDR);
   assign reg_byte = {5'h0, csms_r};

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         csms_r <= CSMS_RESET;
      end else if (ce_in && wr_en_in && hit) begin
         if (bit_access_in) begin
            if (bit_idx_in < 3'(CSMS_FIELD_W)) begin
               csms_r[bit_idx_in[1:0]] <= wdata_in[0];
            end
         end else begin
            csms_r <= wdata_in[CSMS_FIELD_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         rdata_r <= 8'h00;
      end else if (ce_in && rd_en_in) begin
         if (!hit) begin
            rdata_r <= 8'h00;
         end else if (bit_access_in) begin
            rdata_r <= {7'h00, reg_byte[bit_idx_in]};
         end else begin
            rdata_r <= reg_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler for general-purpose timer mode.

   assign div_mask = 8'((9'h1 << csms_r) - 9'h1);
   assign presc_tick = (csms_r != SEL_PROHIBITED) &&
                       ((presc_r & div_mask[PRESC_W-1:0]) == div_mask[PRESC_W-1:0]);

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         presc_r <= '0;
      end else if (ce_in) begin
         if (counter_run_enable_in && !updown_counter_mode_in) begin
            presc_r <= presc_r + 1'b1;
         end else begin
            presc_r <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Count event and direction selection.

   // Edge selection is honoured only in mode 4; other modes use rising edges.
   function automatic logic edge_ok(input logic [1:0] s, input logic r, input logic f);
      edge_ok = ((s == EDGE_RISE) && r) || ((s == EDGE_FALL) && f) ||
                ((s == EDGE_BOTH) && (r || f));
   endfunction

   assign clk_en = edge_ok(clk_edge_sel_in, edges.rise[PIN_CLK], edges.fall[PIN_CLK]);
   assign dir_en = edge_ok(dir_edge_sel_in, edges.rise[PIN_DIR], edges.fall[PIN_DIR]);

   always_comb begin
      ev = 1'b0;
      up = 1'b1;
      if (!updown_counter_mode_in) begin
         src = SRC_PRESC;
      end else if (csms_r[2]) begin
         src = SRC_PIN;
      end else begin
         src = SRC_NONE;
      end
      case (src)
         SRC_PRESC: begin
            ev = presc_tick;
         end
         SRC_PIN: begin
            case (csms_r)
               SEL_UDC_MODE1: begin
                  ev = edges.rise[PIN_CLK];
                  up = ~edges.lvl[PIN_DIR];
               end
               SEL_UDC_MODE2: begin
                  ev = edges.rise[PIN_CLK] ^ edges.rise[PIN_DIR];
                  up = edges.rise[PIN_CLK];
               end
               SEL_UDC_MODE3: begin
                  ev = edges.rise[PIN_CLK];
                  up = edges.lvl[PIN_DIR];
               end
               SEL_UDC_MODE4: begin
                  // Simultaneous edges on both pins are an invalid quadrature step.
                  ev = clk_en ^ dir_en;
                  if (clk_en) begin
                     up = edges.lvl[PIN_CLK] ^ edges.lvl[PIN_DIR];
                  end else begin
                     up = ~(edges.lvl[PIN_CLK] ^ edges.lvl[PIN_DIR]);
                  end
               end
               default: begin
                  ev = 1'b0;
               end
            endcase
         end
         default: begin
            ev = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main counter and registered outputs.

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         cnt_r <= '0;
      end else if (ce_in && counter_run_enable_in && ev) begin
         cnt_r <= up ? cnt_r + 1'b1 : cnt_r - 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         tick_r <= 1'b0;
         up_r <= 1'b1;
      end else if (ce_in) begin
         tick_r <= counter_run_enable_in && ev;
         if (counter_run_enable_in && ev) begin
            up_r <= up;
         end
      end
   end

   assign rdata_out = rdata_r;
   assign main_counter_out = cnt_r;
   assign count_tick_out = tick_r;
   assign count_up_out = up_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in || !ce_in);

   property p_byte_read;
      (rd_en_in && hit && !bit_access_in) |=> (rdata_out == {5'h0, $past(csms_r)});
   endproperty
   a_byte_read: assert property (p_byte_read) else $error("byte read mismatch");

   property p_bit_write;
      (wr_en_in && hit && bit_access_in && bit_idx_in == 3'h1) |=> (csms_r[1] == $past(wdata_in[0]));
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("bit write lost");

   sequence s_div2_run;
      !updown_counter_mode_in && counter_run_enable_in && csms_r == 3'h1;
   endsequence
   property p_div2;
      (s_div2_run and (tick_r && ce_in)) |=> !tick_r;
   endproperty
   a_div2: assert property (p_div2) else $error("divide by 2 tick spacing wrong");

   property p_prohibited;
      (!updown_counter_mode_in && csms_r == SEL_PROHIBITED) |-> !ev;
   endproperty
   a_prohibited: assert property (p_prohibited) else $error("prohibited code counted");

   property p_pin_source;
      (updown_counter_mode_in && ev) |-> (edges.rise != 2'h0 || edges.fall != 2'h0);
   endproperty
   a_pin_source: assert property (p_pin_source) else $error("updown event without pin edge");

   property p_mode1;
      (updown_counter_mode_in && csms_r == SEL_UDC_MODE1 && counter_run_enable_in && ev)
         |=> (count_up_out == !$past(ext_direction_pin_in)) && count_tick_out;
   endproperty
   a_mode1: assert property (p_mode1) else $error("mode 1 direction wrong");

   property p_mode2;
      (updown_counter_mode_in && csms_r == SEL_UDC_MODE2 && edges.rise == 2'h2)
         |-> (ev && !up);
   endproperty
   a_mode2: assert property (p_mode2) else $error("mode 2 down edge missed");

   property p_mode3;
      (updown_counter_mode_in && csms_r == SEL_UDC_MODE3 && edges.rise[PIN_CLK])
         |-> (ev && up == ext_direction_pin_in);
   endproperty
   a_mode3: assert property (p_mode3) else $error("mode 3 direction wrong");

   property p_mode4_edge;
      (updown_counter_mode_in && csms_r == SEL_UDC_MODE4 && clk_edge_sel_in == EDGE_RISE &&
       edges.fall[PIN_CLK] && !edges.rise[PIN_DIR] && !edges.fall[PIN_DIR]) |-> !ev;
   endproperty
   a_mode4_edge: assert property (p_mode4_edge) else $error("disabled edge counted");

   property p_quad_up;
      (updown_counter_mode_in && csms_r == SEL_UDC_MODE4 && counter_run_enable_in &&
       clk_en && !dir_en && !ext_direction_pin_in && ext_count_clock_pin_in)
         |=> (main_counter_out == $past(main_counter_out) + 1'b1);
   endproperty
   a_quad_up: assert property (p_quad_up) else $error("quadrature lead not counted up");

   property p_timer_src;
      (!updown_counter_mode_in && ev) |-> presc_tick;
   endproperty
   a_timer_src: assert property (p_timer_src) else $error("timer event not from prescaler");
endmodule
`default_nettype wire
